// >>> bench/foc_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// Host side model: issues one request per call.
// ************************************************************
module foc_host_model
	import foc_pkg::*;
(
	input  wire logic         sys_clk,
	output logic              clkEn,
	output logic              reqValid,
	output foc_pkg::foc_req_t req,
	output logic              divisorZero
);
	// Idle host: clock enabled, nothing requested.
	initial begin
		clkEn = 1'h1;
		reqValid = 1'h0;
		req = '0;
		divisorZero = 1'h0;
	end

	// Drive just after an edge and hold through the taking edge.
	// The released operand and divisor flag are inverted so stale data can never pass for fresh.
	task automatic send(input logic [63:0] opnd, input logic dbl, input foc_op_t op, input logic dz);
		@(posedge sys_clk);
		#1;
		reqValid = 1'h1;
		req = '{operand: opnd, isDouble: dbl, op: op};
		divisorZero = dz;
		@(posedge sys_clk);
		#1;
		reqValid = 1'h0;
		req.operand = ~opnd;
		divisorZero = ~dz;
	endtask

	// Present a request while the clock enable is low; the block must ignore it.
	task automatic send_frozen(input logic [63:0] opnd, input logic dbl, input foc_op_t op);
		@(posedge sys_clk);
		#1;
		clkEn = 1'h0;
		reqValid = 1'h1;
		req = '{operand: opnd, isDouble: dbl, op: op};
		@(posedge sys_clk);
		#1;
		clkEn = 1'h1;
		reqValid = 1'h0;
		req.operand = ~opnd;
	endtask
endmodule

// >>> bench/fp_operand_classifier_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_count++; $display("BAD %s expected %0h seen %0h", nm, ex, gt); end end
module fp_operand_classifier_test;
	import foc_pkg::*;
	// ************************************************************
	// Signals.
	// ************************************************************
	logic        sys_clk;
	logic        rst_b;
	logic        clkEn;
	logic        reqValid;
	foc_req_t    req;
	logic        divisorZero;
	logic        decValid;
	foc_dec_t    dec;
	logic [63:0] result;
	logic        resultValid;
	logic        invalidTrap;
	logic [2:0]  excCode;
	int          err_count;
	int          samples_checked;
	// Reserved operand table: infinity, negative infinity, denormals.
	logic [63:0] rsvVal [4] = '{64'h0000_0000_7F80_0000, 64'hFFF0_0000_0000_0000, 64'h0000_0000_807F_FFFF, 64'h1};
	logic        rsvDbl [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
	foc_class_t  rsvCls [4] = '{FOC_CLS_INF_NAN, FOC_CLS_INF_NAN, FOC_CLS_DENORM, FOC_CLS_DENORM};

	foc_host_model host (.sys_clk(sys_clk), .clkEn(clkEn), .reqValid(reqValid), .req(req),
		.divisorZero(divisorZero));
	foc_classifier dut (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .reqValid(reqValid), .req(req),
		.divisorZero(divisorZero), .decValid_ff(decValid), .dec_ff(dec), .result_ff(result),
		.resultValid_ff(resultValid), .invalidTrap_ff(invalidTrap), .exception_code_field_ff(excCode));

	// Free running 40 MHz clock.
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ************************************************************
	// Shared request and judgement.
	// ************************************************************
	// Only the low word is meaningful for single precision results.
	task automatic run(input logic [63:0] v, input logic dbl, input foc_op_t op, input logic dz,
		input foc_class_t cls, input logic trap, input logic [63:0] res);
		logic resV;
		resV = !trap && (op == FOC_OP_MOVE || op == FOC_OP_NEG);
		host.send(v, dbl, op, dz);
		`CHK("decValid", 1'h1, decValid)
		`CHK("cls", cls, dec.cls)
		`CHK("sign", v[dbl ? 63 : 31], dec.sign)
		`CHK("trap", trap, invalidTrap)
		`CHK("resultValid", resV, resultValid)
		`CHK("code", (trap ? EXC_INVALID : EXC_NONE), excCode)
		if (resV) `CHK("result", (dbl ? res : {32'h0, res[31:0]}), (dbl ? result : {32'h0, result[31:0]}))
	endtask

	// Normalized operands, including both exponent boundaries.
	task automatic t_normal;
		run(64'h3F80_0000, 1'h0, FOC_OP_NEG, 1'h0, FOC_CLS_NORM, 1'h0, 64'hBF80_0000);
		`CHK("trueExp", 13'h0000, dec.trueExp)
		`CHK("signif", 53'h10_0000_0000_0000, dec.significand)
		run(64'h0080_0000, 1'h0, FOC_OP_ARITH, 1'h0, FOC_CLS_NORM, 1'h0, 64'h0);
		`CHK("trueExp", 13'h1F82, dec.trueExp)
		run(64'h7F7F_FFFF, 1'h0, FOC_OP_ARITH, 1'h0, FOC_CLS_NORM, 1'h0, 64'h0);
		`CHK("trueExp", 13'h007F, dec.trueExp)
		`CHK("signif", 53'h1F_FFFF_E000_0000, dec.significand)
		run(64'hBFF8_0000_0000_0000, 1'h1, FOC_OP_MOVE, 1'h0, FOC_CLS_NORM, 1'h0, 64'hBFF8_0000_0000_0000);
		`CHK("expField", 11'h3FF, dec.expField)
		`CHK("signif", 53'h18_0000_0000_0000, dec.significand)
		run(64'h4000_0000_0000_0000, 1'h1, FOC_OP_NEG, 1'h0, FOC_CLS_NORM, 1'h0, 64'hC000_0000_0000_0000);
		`CHK("trueExp", 13'h0001, dec.trueExp)
	endtask

	// Both zeroes, no hidden one, no trap.
	task automatic t_zero;
		run(64'h0, 1'h0, FOC_OP_ARITH, 1'h0, FOC_CLS_PZERO, 1'h0, 64'h0);
		`CHK("signif", 53'h0, dec.significand)
		run(64'h8000_0000_0000_0000, 1'h1, FOC_OP_NEG, 1'h0, FOC_CLS_NZERO, 1'h0, 64'h0);
	endtask

	// Infinities and denormals, single and double, under move, negate and arithmetic; no NaN is driven.
	task automatic t_reserved;
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 3; k++) begin
				run(rsvVal[i], rsvDbl[i], foc_op_t'(k), 1'h0, rsvCls[i], (k != 0), rsvVal[i]);
			end
		end
	endtask

	// Zero over zero traps; a clean request after it clears the code.
	task automatic t_divide;
		run(64'h0, 1'h0, FOC_OP_DIV, 1'h1, FOC_CLS_PZERO, 1'h1, 64'h0);
		run(64'h0, 1'h0, FOC_OP_DIV, 1'h0, FOC_CLS_PZERO, 1'h0, 64'h0);
		run(64'h8000_0000_0000_0000, 1'h1, FOC_OP_DIV, 1'h1, FOC_CLS_NZERO, 1'h1, 64'h0);
		run(64'h3F80_0000, 1'h0, FOC_OP_DIV, 1'h1, FOC_CLS_NORM, 1'h0, 64'h0);
		run(64'h3F80_0000, 1'h0, FOC_OP_MOVE, 1'h0, FOC_CLS_NORM, 1'h0, 64'h3F80_0000);
	endtask

	// A request under a low clock enable must leave every output as it was.
	task automatic t_freeze;
		run(64'h7F80_0000, 1'h0, FOC_OP_ARITH, 1'h0, FOC_CLS_INF_NAN, 1'h1, 64'h0);
		host.send_frozen(64'h3F80_0000, 1'h0, FOC_OP_MOVE);
		`CHK("frozenValid", 1'h0, decValid)
		`CHK("frozenCls", FOC_CLS_INF_NAN, dec.cls)
		`CHK("frozenResV", 1'h0, resultValid)
		`CHK("frozenCode", EXC_INVALID, excCode)
	endtask

	// Mid-run reset clears every output at once; the first request after it works.
	task automatic t_reset;
		run(64'h7F80_0000, 1'h0, FOC_OP_MOVE, 1'h0, FOC_CLS_INF_NAN, 1'h0, 64'h7F80_0000);
		run(64'h7F80_0000, 1'h0, FOC_OP_ARITH, 1'h0, FOC_CLS_INF_NAN, 1'h1, 64'h0);
		rst_b = 1'h0;
		#1;
		`CHK("rstValid", 1'h0, decValid)
		`CHK("rstTrap", 1'h0, invalidTrap)
		`CHK("rstResult", 64'h0, result)
		`CHK("rstExp", 11'h000, dec.expField)
		`CHK("rstMidCode", EXC_RESET, excCode)
		@(posedge sys_clk);
		#1;
		rst_b = 1'h1;
		run(64'h0, 1'h0, FOC_OP_NEG, 1'h0, FOC_CLS_PZERO, 1'h0, 64'h8000_0000);
	endtask

	// ************************************************************
	// Verdict.
	// ************************************************************
	task automatic close_out;
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_b = 1'h0;
		repeat (10) @(posedge sys_clk);
		#1;
		`CHK("rstCode", EXC_RESET, excCode)
		rst_b = 1'h1;
		t_normal();
		t_zero();
		t_reserved();
		t_freeze();
		t_reset();
		t_divide();
		close_out();
	end
endmodule

// >>> common/foc_pkg.sv
package foc_pkg;

	// ************************************************************
	// Operand format constants.
	// ************************************************************

	// Single precision field layout.
	localparam int SGL_SIGN_POS = 31;
	localparam int SGL_EXP_MSB  = 30;
	localparam int SGL_EXP_LSB  = 23;
	localparam int SGL_FRAC_MSB = 22;
	localparam int SGL_EXP_W    = 8;
	localparam int SGL_FRAC_W   = 23;

	// Double precision field layout.
	localparam int DBL_SIGN_POS = 63;
	localparam int DBL_EXP_MSB  = 62;
	localparam int DBL_EXP_LSB  = 52;
	localparam int DBL_FRAC_MSB = 51;
	localparam int DBL_EXP_W    = 11;
	localparam int DBL_FRAC_W   = 52;

	// Exponent biases.
	localparam logic signed [12:0] SGL_BIAS = 13'sh007F;
	localparam logic signed [12:0] DBL_BIAS = 13'sh03FF;

	// Exception code for an invalid operation, and the no-exception code.
	localparam logic [2:0] EXC_NONE    = 3'h0;
	localparam logic [2:0] EXC_INVALID = 3'h5;

	// Reset values.
	localparam logic [2:0] EXC_RESET = 3'h0;

	// Operand class.
	typedef enum logic [2:0] {
		FOC_CLS_NORM,
		FOC_CLS_PZERO,
		FOC_CLS_NZERO,
		FOC_CLS_INF_NAN,
		FOC_CLS_DENORM
	} foc_class_t;

	// Operation kinds seen by the classifier.
	typedef enum logic [1:0] {
		FOC_OP_MOVE,
		FOC_OP_NEG,
		FOC_OP_ARITH,
		FOC_OP_DIV
	} foc_op_t;

	// A request: operand, its width, and the operation it feeds.
	typedef struct packed {
		logic [63:0] operand;
		logic        isDouble;
		foc_op_t     op;
	} foc_req_t;

	// Decoded operand, in a common wide layout.
	typedef struct packed {
		logic                sign;
		logic [10:0]         expField;
		logic signed [12:0]  trueExp;
		logic [52:0]         significand;
		foc_class_t          cls;
	} foc_dec_t;

endpackage

// >>> rtl/foc_classifier.sv
`timescale 1ns/10ps
module foc_classifier
	import foc_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             clkEn,
	input  wire logic             reqValid,
	input  wire foc_pkg::foc_req_t req,
	input  wire logic             divisorZero,
	output logic                  decValid_ff,
	output foc_pkg::foc_dec_t     dec_ff,
	output logic [63:0]           result_ff,
	output logic                  resultValid_ff,
	output logic                  invalidTrap_ff,
	output logic [2:0]            exception_code_field_ff
);
	import foc_pkg::*;

	// ************************************************************
	// Field extraction.
	// ************************************************************

	logic        opSign;   // Sign bit of the selected format.
	logic [10:0] opExp;    // Exponent field, zero extended.
	logic [51:0] opFrac;   // Fraction field, left aligned for single.
	logic        expZero;  // Exponent field all zeroes.
	logic        expOnes;  // Exponent field all ones.
	logic        fracZero; // Fraction field all zeroes.

	// Pick fields by width; single fraction is left aligned so the binary point sits in one place.
	always_comb begin
		if (req.isDouble) begin
			opSign  = req.operand[DBL_SIGN_POS];
			opExp   = req.operand[DBL_EXP_MSB:DBL_EXP_LSB];
			opFrac  = req.operand[DBL_FRAC_MSB:0];
			expOnes = &req.operand[DBL_EXP_MSB:DBL_EXP_LSB];
		end else begin
			opSign  = req.operand[SGL_SIGN_POS];
			opExp   = {3'h0, req.operand[SGL_EXP_MSB:SGL_EXP_LSB]};
			opFrac  = {req.operand[SGL_FRAC_MSB:0], 29'h00000000};
			expOnes = &req.operand[SGL_EXP_MSB:SGL_EXP_LSB];
		end
		expZero  = (opExp == 11'h000);
		fracZero = (opFrac == 52'h0000000000000);
	end

	// ************************************************************
	// Classification.
	// ************************************************************

	foc_class_t       nxtCls;      // Class of the incoming operand.
	logic             isReserved;  // Infinity, NaN or denormal.
	logic signed [12:0] nxtTrueExp; // Exponent with the bias removed.

	// Exponent decides first; zero versus denormal only when it is all zeroes.
	always_comb begin
		if (expOnes) begin
			nxtCls = FOC_CLS_INF_NAN;
		end else if (expZero && fracZero) begin
			nxtCls = opSign ? FOC_CLS_NZERO : FOC_CLS_PZERO;
		end else if (expZero) begin
			nxtCls = FOC_CLS_DENORM;
		end else begin
			nxtCls = FOC_CLS_NORM;
		end
		isReserved = (nxtCls == FOC_CLS_INF_NAN) || (nxtCls == FOC_CLS_DENORM);
		// The sign of the value is applied by the consumer as (-1)^sign.
		nxtTrueExp = $signed({2'b00, opExp}) - (req.isDouble ? DBL_BIAS : SGL_BIAS);
	end

	// ************************************************************
	// Decode register.
	// ************************************************************

	// Decoded fields; zero and reserved forms carry no hidden one.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_ff      <= '0;
			decValid_ff <= 1'b0;
		end else if (clkEn) begin
			decValid_ff <= reqValid;
			if (reqValid) begin
				dec_ff.sign        <= opSign;
				dec_ff.expField    <= opExp;
				dec_ff.trueExp     <= nxtTrueExp;
				dec_ff.significand <= {nxtCls == FOC_CLS_NORM, opFrac};
				dec_ff.cls         <= nxtCls;
			end
		end
	end

	// ************************************************************
	// Move and negate result path.
	// ************************************************************

	logic invalidNow; // Trap condition for this request.

	// A plain move passes anything; every other use of a reserved operand traps,
	// as does zero divided by zero.
	assign invalidNow = reqValid &&
		((isReserved && req.op != FOC_OP_MOVE) ||
		 (req.op == FOC_OP_DIV && !isReserved && expZero && divisorZero));

	// Result of move or negate; a trapped request produces no result so negate never
	// generates a reserved form, while a move passes a reserved operand through unchanged.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			result_ff      <= 64'h0000000000000000;
			resultValid_ff <= 1'b0;
		end else if (clkEn) begin
			resultValid_ff <= 1'b0;
			if (reqValid && !invalidNow) begin
				case (req.op)
					FOC_OP_MOVE: begin
						result_ff      <= req.operand;
						resultValid_ff <= 1'b1;
					end
					FOC_OP_NEG: begin
						// Only the sign flips; exponent and fraction stay put.
						result_ff <= req.operand ^
							(req.isDouble ? 64'h8000000000000000 : 64'h0000000080000000);
						resultValid_ff <= 1'b1;
					end
					default: begin
						resultValid_ff <= 1'b0;
					end
				endcase
			end
		end
	end

	// ************************************************************
	// Exception reporting.
	// ************************************************************

	// The code is rewritten on every request taken while the clock enable is high: invalid, otherwise none.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			invalidTrap_ff          <= 1'b0;
			exception_code_field_ff <= EXC_RESET;
		end else if (clkEn) begin
			invalidTrap_ff <= invalidNow;
			if (reqValid) begin
				exception_code_field_ff <= invalidNow ? EXC_INVALID : EXC_NONE;
			end
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	property p_trapCode;
		clkEn && reqValid && isReserved && req.op == FOC_OP_ARITH |=>
			invalidTrap_ff && exception_code_field_ff == 3'h5;
	endproperty
	a_trapCode: assert property (p_trapCode) else $error("reserved operand did not trap");

	property p_moveNoTrap;
		clkEn && reqValid && req.op == FOC_OP_MOVE |=> !invalidTrap_ff && resultValid_ff;
	endproperty
	a_moveNoTrap: assert property (p_moveNoTrap) else $error("move trapped or gave no result");

	property p_codeMatches;
		invalidTrap_ff |-> exception_code_field_ff == EXC_INVALID;
	endproperty
	a_codeMatches: assert property (p_codeMatches) else $error("trap without invalid code");

	property p_negSign;
		clkEn && reqValid && req.op == FOC_OP_NEG && !isReserved |=>
			result_ff == ($past(req.operand) ^ ($past(req.isDouble) ? 64'h8000000000000000 : 64'h0000000080000000));
	endproperty
	a_negSign: assert property (p_negSign) else $error("negate changed more than sign");

	property p_zeroClass;
		clkEn && reqValid && expZero && fracZero |=>
			dec_ff.cls == ($past(opSign) ? FOC_CLS_NZERO : FOC_CLS_PZERO);
	endproperty
	a_zeroClass: assert property (p_zeroClass) else $error("zero misclassified");

	property p_onesReserved;
		clkEn && reqValid && expOnes |=> dec_ff.cls == FOC_CLS_INF_NAN;
	endproperty
	a_onesReserved: assert property (p_onesReserved) else $error("all-ones exponent not reserved");

	property p_denorm;
		clkEn && reqValid && expZero && !fracZero |=> dec_ff.cls == FOC_CLS_DENORM;
	endproperty
	a_denorm: assert property (p_denorm) else $error("denormal misclassified");

	property p_hiddenOne;
		decValid_ff |-> dec_ff.significand[52] == (dec_ff.cls == FOC_CLS_NORM);
	endproperty
	a_hiddenOne: assert property (p_hiddenOne) else $error("hidden bit wrong");

	property p_bias;
		clkEn && reqValid && !req.isDouble && req.operand[30:23] == 8'h7F |=> dec_ff.trueExp == 13'sh0000;
	endproperty
	a_bias: assert property (p_bias) else $error("single bias wrong");

	// Judges the produced word itself, so a broken trap gate on negate shows up here.
	property p_noReservedOut;
		resultValid_ff && $past(req.op) == FOC_OP_NEG |->
			($past(req.isDouble) ?
				(!(&result_ff[DBL_EXP_MSB:DBL_EXP_LSB]) &&
				 ((|result_ff[DBL_EXP_MSB:DBL_EXP_LSB]) || result_ff[DBL_FRAC_MSB:0] == 52'h0000000000000)) :
				(!(&result_ff[SGL_EXP_MSB:SGL_EXP_LSB]) &&
				 ((|result_ff[SGL_EXP_MSB:SGL_EXP_LSB]) || result_ff[SGL_FRAC_MSB:0] == 23'h000000)));
	endproperty
	a_noReservedOut: assert property (p_noReservedOut) else $error("reserved result produced");

	c_move: cover property (clkEn && reqValid && req.op == FOC_OP_MOVE && isReserved);
	c_trap: cover property (invalidTrap_ff);
	c_negZero: cover property (decValid_ff && dec_ff.cls == FOC_CLS_NZERO);
	c_double: cover property (clkEn && reqValid && req.isDouble && nxtCls == FOC_CLS_NORM);

endmodule
